//--- core/srw_pkg.sv
// Constants and carrier types for the supervisory reset watchdog
package srw_pkg;

    localparam int unsigned CLK_PERIOD_PS       = 8000;
    localparam longint      RESET_HOLD_MS       = 200;
    localparam longint      WATCHDOG_PERIOD_MS  = 1600;
    // Exact cycle counts at 125 MHz; both far above 4096 so the top exposes them
    localparam longint      RESET_HOLD_CYCLES   =
        (RESET_HOLD_MS * 64'd1_000_000_000) / CLK_PERIOD_PS;
    localparam longint      WATCHDOG_CYCLES     =
        (WATCHDOG_PERIOD_MS * 64'd1_000_000_000) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W               = 28;

    // Kick input as seen at the pin: level plus whether anything drives it
    typedef struct packed {
        logic level;
        logic driven;
    } srw_kick_t;

    typedef enum logic [1:0] {
        SRW_ACTIVE,
        SRW_HOLD,
        SRW_RUN
    } srw_state_t;

endpackage : srw_pkg

//--- core/srw_watchdog_timer.sv
// Watchdog period counter cleared by reset and kick edges
`timescale 1ns/1ps
`default_nettype none
module srw_watchdog_timer #(
    parameter logic [srw_pkg::CNT_W-1:0] PERIOD = srw_pkg::CNT_W'(srw_pkg::WATCHDOG_CYCLES)
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire srw_pkg::srw_kick_t kick,
    input  wire logic              reset_active,
    output var  logic              expired
);
    import srw_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             last_level;
        logic             expired;
    } srw_wdt_state_t;

    srw_wdt_state_t cur;
    srw_wdt_state_t next_cur;

    always_comb
    begin
        next_cur            = cur;
        next_cur.last_level = kick.level;
        next_cur.expired    = 1'b0;
        if (reset_active || !kick.driven)
        begin
            next_cur.count = '0;
        end
        else if (kick.level != cur.last_level)
        begin
            next_cur.count = '0;
        end
        else if (cur.count >= PERIOD - 1'b1)
        begin
            next_cur.count   = '0;
            next_cur.expired = 1'b1;
        end
        else
        begin
            next_cur.count = cur.count + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign expired = cur.expired;

endmodule : srw_watchdog_timer
`default_nettype wire

//--- core/srw_supervisor.sv
// Supervisory reset generator with manual reset and watchdog
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor #(
    parameter logic [srw_pkg::CNT_W-1:0] HOLD_CYCLES =
        srw_pkg::CNT_W'(srw_pkg::RESET_HOLD_CYCLES),
    parameter logic [srw_pkg::CNT_W-1:0] WATCHDOG_CYCLES =
        srw_pkg::CNT_W'(srw_pkg::WATCHDOG_CYCLES)
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               undervoltage,
    input  wire logic               manual_reset_n,
    input  wire srw_pkg::srw_kick_t watchdog_kick_in,
    output var  logic               reset_out_n,
    output var  logic               reset_out
);
    import srw_pkg::*;

    typedef struct packed {
        srw_state_t       state;
        logic [CNT_W-1:0] hold;
        logic             reset_out_n;
        logic             reset_out;
    } srw_sup_state_t;

    srw_sup_state_t cur;
    srw_sup_state_t next_cur;
    logic           wdt_expired;
    logic           cause;

    srw_watchdog_timer #(
        .PERIOD       (WATCHDOG_CYCLES)
    ) u_wdt (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .kick         (watchdog_kick_in),
        .reset_active (cur.state != SRW_RUN),
        .expired      (wdt_expired)
    );

    // Open manual input reads high through the pull-up at the pin
    assign cause = undervoltage || !manual_reset_n;

    always_comb
    begin
        next_cur = cur;
        case (cur.state)
            SRW_ACTIVE:
            begin
                next_cur.hold = '0;
                if (!cause)
                begin
                    next_cur.state = SRW_HOLD;
                end
            end
            SRW_HOLD:
            begin
                if (cause)
                begin
                    next_cur.state = SRW_ACTIVE;
                    next_cur.hold  = '0;
                end
                else if (cur.hold >= HOLD_CYCLES - 1'b1)
                begin
                    next_cur.state = SRW_RUN;
                end
                else
                begin
                    next_cur.hold = cur.hold + 1'b1;
                end
            end
            SRW_RUN:
            begin
                next_cur.hold = '0;
                if (cause)
                begin
                    next_cur.state = SRW_ACTIVE;
                end
                else if (wdt_expired)
                begin
                    next_cur.state = SRW_HOLD;
                end
            end
            default:
            begin
                next_cur.state = SRW_ACTIVE;
            end
        endcase
        // Outputs registered from the next state so both flip in one edge
        next_cur.reset_out_n = (next_cur.state == SRW_RUN);
        next_cur.reset_out   = (next_cur.state != SRW_RUN);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur.state       <= SRW_ACTIVE;
            cur.hold        <= '0;
            cur.reset_out_n <= 1'b0;
            cur.reset_out   <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign reset_out_n = cur.reset_out_n;
    assign reset_out   = cur.reset_out;

endmodule : srw_supervisor
`default_nettype wire

//--- testbench/srw_properties.sv
// Checker for the supervisory reset watchdog
`timescale 1ns/1ps
`default_nettype none
module srw_properties #(parameter int HOLD = 20, parameter int WD = 100) (
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               undervoltage,
    input wire logic               manual_reset_n,
    input wire srw_pkg::srw_kick_t watchdog_kick_in,
    input wire logic               reset_out_n,
    input wire logic               reset_out
);
    import srw_pkg::*;
    int  lo;
    int  st;
    wire cause = undervoltage | ~manual_reset_n;
    wire run   = reset_out_n & watchdog_kick_in.driven;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Causeless low time, and static kick time while running
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) {lo, st} <= '0;
        else
        begin
            lo <= (!reset_out_n && !cause) ? lo + 1 : 0;
            st <= (run && $stable(watchdog_kick_in.level)) ? st + 1 : 0;
        end
    inv_out_a: assert property (reset_out == !reset_out_n)
        else $error("outputs not inverse");
    uv_low_a: assert property (undervoltage |=> !reset_out_n)
        else $error("no reset on undervoltage");
    mr_low_a: assert property (!manual_reset_n |=> !reset_out_n)
        else $error("no reset on manual input");
    mr_hold_a: assert property ($rose(manual_reset_n) |=> !reset_out_n [*8])
        else $error("early release after manual input");
    hold_min_a: assert property ($rose(reset_out_n) |-> lo >= HOLD)
        else $error("hold too short");
    hold_max_a: assert property (lo <= HOLD + 3)
        else $error("hold too long");
    wd_max_a: assert property (st <= WD + 4)
        else $error("watchdog did not expire");
    wd_early_a: assert property ($fell(reset_out_n) && !$past(cause)
        |-> $past(st) >= WD - 2) else $error("reset without cause");
    cover property ($rose(reset_out_n));
    cover property ($fell(reset_out_n) && !$past(cause));
    cover property (undervoltage ##1 !undervoltage);
endmodule : srw_properties
bind srw_supervisor srw_properties #(.HOLD(HOLD_CYCLES), .WD(WATCHDOG_CYCLES)) srw_properties_inst (.*);
`default_nettype wire

//--- testbench/srw_cpu_model.sv
// Processor model that services the kick line
`timescale 1ns/1ps
`default_nettype none
module srw_cpu_model #(parameter int KP = 40) (
    input  wire logic               mclk,
    input  wire logic               reset_out_n,
    input  wire logic               hang,
    input  wire logic               detach,
    output var  srw_pkg::srw_kick_t kick
);
    import srw_pkg::*;
    int n = 0;
    initial kick = '0;
    // Pins float in reset; a floating line shows no steady level
    always @(posedge mclk)
    begin
        n <= (n >= KP - 1 || !reset_out_n) ? 0 : n + 1;
        kick.driven <= reset_out_n && !detach;
        if (!kick.driven || (n == KP - 1 && !hang))
            kick.level <= ~kick.level;
    end
endmodule : srw_cpu_model
`default_nettype wire

//--- testbench/srw_supervisor_tb.sv
// Self-checking bench for the supervisory reset watchdog
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_tb;
    import srw_pkg::*;
    localparam int HOLD = 20;
    localparam int WD   = 100;
    typedef struct {logic uv; logic mr; logic hg; logic dt; int n; logic ex;} srw_row_t;
    srw_row_t  rows [11] = '{'{0,1,0,0,30,1}, '{1,1,0,0,2,0}, '{0,1,0,0,10,0},
        '{1,1,0,0,1,0}, '{0,1,0,0,18,0}, '{0,1,0,0,8,1}, '{0,0,0,0,2,0},
        '{0,0,0,0,50,0}, '{0,1,0,0,18,0}, '{0,1,0,0,300,1}, '{0,1,1,1,400,1}};
    logic      mclk = 0, rst_b = 0, uv = 0, mr = 1, hg = 0, dt = 0, rn, ro;
    srw_kick_t kick;
    int        mismatches = 0, tests_run = 0, k;
    srw_supervisor #(.HOLD_CYCLES(CNT_W'(HOLD)), .WATCHDOG_CYCLES(CNT_W'(WD)))
        srw_supervisor_inst (.mclk(mclk), .rst_b(rst_b), .undervoltage(uv),
        .manual_reset_n(mr), .watchdog_kick_in(kick), .reset_out_n(rn), .reset_out(ro));
    srw_cpu_model srw_cpu_model_inst (.mclk(mclk), .reset_out_n(rn), .hang(hg),
        .detach(dt), .kick(kick));
    task automatic chk(string what, logic seen, logic exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial forever #4 mclk = ~mclk;
    initial
    begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge mclk);
        #1 rst_b = 1;
        foreach (rows[i])
        begin
            {uv, mr, hg, dt} = {rows[i].uv, rows[i].mr, rows[i].hg, rows[i].dt};
            #(8 * rows[i].n);
            chk("reset_out_n", rn, rows[i].ex);
            chk("reset_out", ro, !rows[i].ex);
        end
        dt = 0;
        for (k = 0; rn === 1'b1 && k < 300; k++) #8;
        chk("expiry_span", k >= WD && k <= WD + 6, 1'b1);
        for (k = 0; rn !== 1'b1 && k < 300; k++) #8;
        chk("expiry_hold", k >= HOLD && k <= HOLD + 3, 1'b1);
        // Mid-run reset: reset_out_n falls and reset_out rises at once, full hold follows release
        rst_b = 0;
        #1 chk("reset_out", ro, 1'b1);
        chk("reset_out_n", rn, 1'b0);
        #7 rst_b = 1;
        #(8 * 10);
        chk("reset_out_n", rn, 1'b0);
        #(8 * 20);
        chk("reset_out_n", rn, 1'b1);
        chk("reset_out", ro, 1'b0);
        summarize();
    end
endmodule : srw_supervisor_tb
`default_nettype wire
